// ---- inc/pas_pkg.sv ----
// Purpose: Shared constants for the pipelined converter output logic.
// Assumes: One system clock mclk_i at 200 MHz; conversion clock arrives as a sampled input.
// Notes:   Timing figures are kept in their own units and turned into cycle counts here.
package pas_pkg;
    // Width of the output word.
    localparam int unsigned DATA_W          = 10;
    // Pipeline delay in conversion clocks between sample and output word.
    localparam int unsigned PIPE_DEPTH      = 6;
    // System clock rate and the slowest allowed conversion clock.
    localparam int unsigned SYS_CLK_MHZ     = 200;
    localparam int unsigned MIN_CONV_MHZ    = 20;
    // Longest conversion period allowed, in system cycles, rounded down.
    localparam int unsigned MAX_PERIOD_CYC  = SYS_CLK_MHZ / MIN_CONV_MHZ;
    // Width of the period watchdog counter.
    localparam int unsigned WD_W            = 5;
    // Offset binary midscale code, first code above the zero crossing.
    localparam logic [9:0]  MIDSCALE_CODE   = 10'h200;
    // Reset value of the output word.
    localparam logic [9:0]  DATA_RST        = 10'h000;
    // Full scale selections of the three-level strap.
    typedef enum logic [1:0] {PAS_FS_2V0, PAS_FS_1V5, PAS_FS_1V0} pas_fs_t;
    // Strap input codes: high and low; any other code reads as floating.
    localparam logic [1:0]  STRAP_HIGH      = 2'h1;
    localparam logic [1:0]  STRAP_LOW       = 2'h0;
endpackage

// ---- hdl/pas_pipe.sv ----
// Purpose: Sample pipeline stage chain, cleared on demand.
// Assumes: Advances only on the conversion clock enable.
// Notes:   A flush wipes every stage and its valid tag.
`timescale 1ns/10ps
`default_nettype none
module pas_pipe
    import pas_pkg::*;
#(
    parameter int unsigned W     = DATA_W,
    parameter int unsigned DEPTH = PIPE_DEPTH
) (
    // Clock and reset.
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    // Control.
    input  wire logic         adv_i,
    input  wire logic         flush_i,
    // Data in and out.
    input  wire logic [W-1:0] din_i,
    output logic      [W-1:0] dout_o,
    output logic              dvalid_o
);
    // Stage storage and valid tags.
    logic [W-1:0] stage_reg  [DEPTH];
    logic [W-1:0] stage_next [DEPTH];
    logic [DEPTH-1:0] vld_reg;
    logic [DEPTH-1:0] vld_next;

    // Next stage values: shift on advance, wipe on flush.
    always_comb begin
        stage_next = stage_reg;
        vld_next   = vld_reg;
        if (flush_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_next[i] = '0;
            end
            vld_next = '0;
        end else if (adv_i) begin
            stage_next[0] = din_i;
            for (int i = 1; i < DEPTH; i++) begin
                stage_next[i] = stage_reg[i-1];
            end
            vld_next = {vld_reg[DEPTH-2:0], 1'b1};
        end
    end

    // Register the stages.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_reg[i] <= '0;
            end
            vld_reg <= '0;
        end else begin
            stage_reg <= stage_next;
            vld_reg   <= vld_next;
        end
    end

    // Last stage feeds the output formatter.
    assign dout_o   = stage_reg[DEPTH-1];
    assign dvalid_o = vld_reg[DEPTH-1];
endmodule
`default_nettype wire

// ---- hdl/pas_top.sv ----
// Purpose: Digital output side of a 10-bit pipelined sampling converter.
// Assumes: conv_clk_i is sampled on mclk_i; digitised samples arrive on sample_i.
// Notes:   Undefined outputs in power-down are modelled as a held zero with valid low.
// How it works
// - Too slow clock makes data inaccurate.
// - Conversion clock times sampling and state machine; the core state machine here steps on mclk_i, not on conv_edge.
// - Hold input high keeps core powered down.
// - Output word undefined during power-down.
// - Power-down wipes every pipeline sample.
// - Format select high gives two's complement.
// - Ten parallel output lines carry each result.
// - Three-level strap selects full scale range.
// - New word each clock after pipeline delay.
// - Offset binary midscale between 1ff and 200.
`timescale 1ns/10ps
`default_nettype none
module pas_top
    import pas_pkg::*;
#(
    parameter int unsigned W     = DATA_W,
    parameter int unsigned DEPTH = PIPE_DEPTH
) (
    // Clock and reset.
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    // Conversion clock and sampled code, offset binary.
    input  wire logic         conv_clk_i,
    input  wire logic [W-1:0] sample_i,
    // Control pins.
    input  wire logic         low_power_hold_i,
    input  wire logic         format_select_i,
    input  wire logic [1:0]   full_scale_strap_i,
    // Output word and status.
    output logic      [W-1:0] data_o,
    output logic              data_valid_o,
    output logic              powered_down_o,
    output logic              clock_fault_o,
    output logic      [1:0]   full_scale_o
);
    // Core state machine.
    typedef enum logic [1:0] {PAS_ST_DOWN, PAS_ST_RUN} pas_state_t;
    pas_state_t state_reg;
    pas_state_t state_next;
    logic       pd_reg;  // Registered power-down flag, drives powered_down_o.
    logic       pd_next; // Next power-down flag, follows the next state.

    // Conversion clock edge detection.
    logic conv_prev_reg;
    logic conv_prev_next;
    logic conv_edge;

    // Period watchdog.
    logic [WD_W-1:0] wd_reg;
    logic [WD_W-1:0] wd_next;
    logic            fault_reg;
    logic            fault_next;

    // Output registers.
    logic [W-1:0] data_reg;
    logic [W-1:0] data_next;
    logic         valid_reg;
    logic         valid_next;
    logic [1:0]   fs_reg;
    logic [1:0]   fs_next;

    // Pipeline wires.
    logic [W-1:0] pipe_word;
    logic         pipe_valid;
    logic         flush;

    // Map the three-level strap to a full scale code.
    function automatic logic [1:0] strap_decode(input logic [1:0] s);
        logic [1:0] r;
        r = 2'(PAS_FS_1V0);
        if (s == STRAP_HIGH) begin
            r = 2'(PAS_FS_2V0);
        end else if (s == STRAP_LOW) begin
            r = 2'(PAS_FS_1V5);
        end
        return r;
    endfunction

    // Format a word: flip the top bit for two's complement.
    function automatic logic [W-1:0] fmt(input logic [W-1:0] ob, input logic tc);
        logic [W-1:0] r;
        r = ob;
        if (tc) begin
            r[W-1] = ~ob[W-1];
        end
        return r;
    endfunction

    // Rising edge of the conversion clock drives the pipeline, the output word and the watchdog.
    assign conv_edge = conv_clk_i & ~conv_prev_reg;
    // Pipeline wiped whenever the core is down.
    assign flush     = (state_reg == PAS_ST_DOWN) || low_power_hold_i;

    // Sample pipeline.
    pas_pipe #(
        .W     (W),
        .DEPTH (DEPTH)
    ) u_pipe (
        .mclk_i   (mclk_i),
        .rstn_i   (rstn_i),
        .adv_i    (conv_edge),
        .flush_i  (flush),
        .din_i    (sample_i),
        .dout_o   (pipe_word),
        .dvalid_o (pipe_valid)
    );

    // Power state: hold input high forces and keeps power-down.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PAS_ST_DOWN: begin
                if (!low_power_hold_i) begin
                    state_next = PAS_ST_RUN;
                end
            end
            PAS_ST_RUN: begin
                if (low_power_hold_i) begin
                    state_next = PAS_ST_DOWN;
                end
            end
            default: begin
                state_next = PAS_ST_DOWN;
            end
        endcase
        // The flag mirrors the state so the output pin comes from its own flip-flop.
        pd_next = (state_next == PAS_ST_DOWN);
    end

    // Watchdog: too long between edges marks data as inaccurate.
    always_comb begin
        conv_prev_next = conv_clk_i;
        wd_next        = wd_reg;
        fault_next     = fault_reg;
        if (state_reg == PAS_ST_DOWN) begin
            wd_next    = '0;
            fault_next = 1'b0;
        end else if (conv_edge) begin
            wd_next    = '0;
            fault_next = 1'b0;
        end else if (wd_reg >= WD_W'(MAX_PERIOD_CYC)) begin
            fault_next = 1'b1;
        end else begin
            wd_next = wd_reg + WD_W'(1);
        end
    end

    // Output word: new word each conversion edge, invalid while down.
    always_comb begin
        data_next  = data_reg;
        valid_next = valid_reg;
        fs_next    = strap_decode(full_scale_strap_i);
        if (flush) begin
            data_next  = DATA_RST;
            valid_next = 1'b0;
        end else if (conv_edge) begin
            data_next  = fmt(pipe_word, format_select_i);
            valid_next = pipe_valid && !fault_reg;
        end else if (fault_reg) begin
            // A stalled clock lets stored charge decay, so the held word is no longer trusted.
            valid_next = 1'b0;
        end
    end

    // Register all state.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_reg     <= PAS_ST_DOWN;
            pd_reg        <= 1'b1;
            conv_prev_reg <= 1'b0;
            wd_reg        <= '0;
            fault_reg     <= 1'b0;
            data_reg      <= DATA_RST;
            valid_reg     <= 1'b0;
            fs_reg        <= 2'(PAS_FS_1V0);
        end else begin
            state_reg     <= state_next;
            pd_reg        <= pd_next;
            conv_prev_reg <= conv_prev_next;
            wd_reg        <= wd_next;
            fault_reg     <= fault_next;
            data_reg      <= data_next;
            valid_reg     <= valid_next;
            fs_reg        <= fs_next;
        end
    end

    // Outputs straight from flip-flops.
    assign data_o         = data_reg;
    assign data_valid_o   = valid_reg;
    assign powered_down_o = pd_reg;
    assign clock_fault_o  = fault_reg;
    assign full_scale_o   = fs_reg;
endmodule
`default_nettype wire

// ---- verification/pas_cap_model.sv ----
// Purpose: Capture-side model that makes the conversion clock and the samples.
// Assumes: Changes its outputs on the falling mclk edge.
// Notes: Samples count up from 1fc so the midscale codes pass by.
`timescale 1ns/10ps
`default_nettype none
module pas_cap_model
    import pas_pkg::*;
(
    // Clock in, conversion clock and sample out.
    input  wire logic              mclk_i,
    output logic                   conv_clk_o,
    output logic [DATA_W-1:0]      sample_o
);
    int hi  = 3;    // High phase in mclk cycles.
    int lo  = 3;    // Low phase in mclk cycles.
    bit run = 1'b1; // The clock stands low while this is clear.
    // Each period runs whole; the sample moves in the low phase, away from the rising edge.
    initial begin
        conv_clk_o = 1'b0;
        sample_o   = 10'h1fc;
        forever begin
            @(negedge mclk_i);
            if (run) begin
                conv_clk_o = 1'b1;
                repeat (hi) @(negedge mclk_i);
                conv_clk_o = 1'b0;
                sample_o   = sample_o + 10'h001;
                repeat (lo - 1) @(negedge mclk_i);
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/pas_top_checker.sv ----
// Purpose: Port assertions for the converter output logic.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Helper counters track conversion edges and gaps between them.
`timescale 1ns/10ps
`default_nettype none
module pas_top_checker
    import pas_pkg::*;
#(
    parameter int unsigned W     = DATA_W,
    parameter int unsigned DEPTH = PIPE_DEPTH
) (
    // Watched ports.
    input wire logic         mclk_i,
    input wire logic         rstn_i,
    input wire logic         conv_clk_i,
    input wire logic [W-1:0] sample_i,
    input wire logic         low_power_hold_i,
    input wire logic         format_select_i,
    input wire logic [1:0]   full_scale_strap_i,
    input wire logic [W-1:0] data_o,
    input wire logic         data_valid_o,
    input wire logic         powered_down_o,
    input wire logic         clock_fault_o,
    input wire logic [1:0]   full_scale_o
);
    logic       prev_reg; // Conversion clock one cycle back.
    logic [4:0] gap_reg;  // Cycles since the last conversion edge.
    logic [3:0] edge_reg; // Conversion edges since leaving power-down.
    wire        conv_edge = conv_clk_i & ~prev_reg;
    // Both counts saturate so they never wrap back to a small value.
    always_ff @(posedge mclk_i) begin
        prev_reg <= conv_clk_i;
        if (!rstn_i || conv_edge || powered_down_o) gap_reg <= 5'h00;
        else if (gap_reg != 5'h1f) gap_reg <= gap_reg + 5'h01;
        if (!rstn_i || powered_down_o) edge_reg <= 4'h0;
        else if (conv_edge && edge_reg != 4'hf) edge_reg <= edge_reg + 4'h1;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    AST_PD_ENTER: assert property (low_power_hold_i |=> powered_down_o)
        else $error("power-down not entered");
    AST_PD_LEAVE: assert property (!low_power_hold_i |=> !powered_down_o)
        else $error("power-down not left");
    AST_PD_WORD: assert property (low_power_hold_i [*2]
        |=> data_o == DATA_RST && !data_valid_o)
        else $error("word shown in power-down");
    AST_REFILL: assert property (data_valid_o |-> edge_reg >= 4'(DEPTH + 1))
        else $error("valid before pipeline refilled");
    AST_WORD_HOLD: assert property (!conv_edge && !low_power_hold_i && !powered_down_o
        && !clock_fault_o |=> $stable(data_o))
        else $error("word changed without conversion edge");
    AST_FAULT_SET: assert property (gap_reg > 5'(MAX_PERIOD_CYC) |-> clock_fault_o)
        else $error("stopped clock not flagged");
    AST_FAULT_VALID: assert property (clock_fault_o ##1 clock_fault_o |-> !data_valid_o)
        else $error("valid during clock fault");
    AST_FS_HIGH: assert property (full_scale_strap_i == STRAP_HIGH
        |=> full_scale_o == PAS_FS_2V0)
        else $error("wrong range for high strap");
    AST_FS_LOW: assert property (full_scale_strap_i == STRAP_LOW
        |=> full_scale_o == PAS_FS_1V5)
        else $error("wrong range for low strap");
    AST_FS_FLOAT: assert property (full_scale_strap_i > 2'h1
        |=> full_scale_o == PAS_FS_1V0)
        else $error("wrong range for floating strap");
    COV_REFILL: cover property ($rose(data_valid_o));
    COV_WAKE: cover property ($fell(powered_down_o));
    COV_FAULT: cover property ($rose(clock_fault_o));
endmodule
bind pas_top pas_top_checker #(.W(W), .DEPTH(DEPTH)) chk_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .conv_clk_i(conv_clk_i), .sample_i(sample_i), .low_power_hold_i(low_power_hold_i),
    .format_select_i(format_select_i), .full_scale_strap_i(full_scale_strap_i),
    .data_o(data_o), .data_valid_o(data_valid_o), .powered_down_o(powered_down_o),
    .clock_fault_o(clock_fault_o), .full_scale_o(full_scale_o));
`default_nettype wire

// ---- verification/test_pipelined_adc_sample_output.sv ----
// Purpose: Self-checking bench for the converter output logic.
// Assumes: Bench inputs change on the falling mclk edge.
// Notes: A monitor rebuilds each expected word from the samples it saw.
`timescale 1ns/10ps
`default_nettype none
module test_pipelined_adc_sample_output
    import pas_pkg::*;
();
    logic              mclk_i = 1'b0, rstn_i = 1'b0, cprev = 1'b0;
    logic              conv_clk_i, data_valid_o, powered_down_o, clock_fault_o;
    logic              low_power_hold_i = 1'b0, format_select_i = 1'b0;
    logic [1:0]        full_scale_strap_i = 2'h0, full_scale_o;
    logic [DATA_W-1:0] sample_i, data_o;
    logic [DATA_W-1:0] hist[$]; // Samples seen since the last restart.
    int                miscompares = 0, cmp_count = 0;
    bit                mon = 1'b0;
    always #2.5 mclk_i = ~mclk_i;
    pas_cap_model cap (.mclk_i(mclk_i), .conv_clk_o(conv_clk_i), .sample_o(sample_i));
    pas_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .conv_clk_i(conv_clk_i), .sample_i(sample_i),
        .low_power_hold_i(low_power_hold_i), .format_select_i(format_select_i),
        .full_scale_strap_i(full_scale_strap_i), .data_o(data_o), .data_valid_o(data_valid_o),
        .powered_down_o(powered_down_o), .clock_fault_o(clock_fault_o),
        .full_scale_o(full_scale_o));
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Latch on the rising conversion clock; the word then belongs to the sample six edges back.
    always @(posedge mclk_i) begin
        if (conv_clk_i && !cprev && mon) begin
            hist.push_back(sample_i ^ {format_select_i, 9'h000});
            #1;
            if (hist.size() > PIPE_DEPTH + 1) begin
                chk(data_o, hist[hist.size() - 1 - PIPE_DEPTH]);
                chk({9'h000, data_valid_o}, 10'h001);
            end
        end
        cprev = conv_clk_i;
    end
    task automatic wait_edges(input int n);
        repeat (n) @(posedge conv_clk_i);
        @(negedge mclk_i);
    endtask
    // Words from before a change are dropped by forgetting their samples.
    task automatic restart();
        mon = 1'b0;
        hist.delete();
        repeat (3) @(negedge mclk_i);
        mon = 1'b1;
    endtask
    task automatic t_stream(input bit fmt, input int hi, input int lo);
        format_select_i = fmt;
        cap.hi = hi;
        cap.lo = lo;
        restart();
        wait_edges(16);
    endtask
    task automatic t_strap();
        pas_fs_t fs_exp [4] = '{PAS_FS_1V5, PAS_FS_2V0, PAS_FS_1V0, PAS_FS_1V0};
        for (int i = 0; i < 4; i++) begin
            full_scale_strap_i = 2'(i);
            repeat (2) @(negedge mclk_i);
            chk({8'h00, full_scale_o}, {8'h00, fs_exp[i]});
        end
    endtask
    task automatic t_powerdown();
        mon = 1'b0;
        low_power_hold_i = 1'b1;
        repeat (20) @(negedge mclk_i);
        chk({8'h00, powered_down_o, data_valid_o}, 10'h002);
        chk(data_o, DATA_RST);
        low_power_hold_i = 1'b0;
        wait_edges(5);
        chk({8'h00, powered_down_o, data_valid_o}, 10'h000);
        restart();
        wait_edges(12);
    endtask
    task automatic t_fault();
        mon = 1'b0;
        cap.run = 1'b0;
        repeat (30) @(negedge mclk_i);
        chk({8'h00, clock_fault_o, data_valid_o}, 10'h002);
        cap.run = 1'b1;
        wait_edges(12);
        chk({9'h000, clock_fault_o}, 10'h000);
        restart();
        wait_edges(12);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge mclk_i);
        rstn_i = 1'b1;
        t_strap();
        t_stream(1'b0, 3, 3);
        t_stream(1'b1, 3, 2);
        t_stream(1'b0, 5, 5);
        t_powerdown();
        t_fault();
        stop_test();
    end
    // Watchdog well beyond the roughly 4 us the tests need.
    initial begin
        #30000;
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
